/* logic/lcdpb_top.sv */
// apb register file of the display pin and bias configuration block
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module lcdpb_top #(
  parameter int SEG_MAX = 384,
  parameter logic COM_SHARED = 1'b1,
  parameter logic [53:0] DEDICATED = 54'h0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] mux_ratio,
  output lcdpb_pkg::lcdpb_bias_s bias,
  output logic [53:0] seg_lcd_func
);
  logic [15:0] vctl_reg;
  logic [15:0] sel_reg [lcdpb_pkg::NUM_SEL];
  logic [63:0] sel_flat;
  logic [31:0] rdata_next;
  logic hit_vctl;
  logic [3:0] hit_sel;
  logic mapped;
  logic setup;
  logic access_wr;

  always_comb begin
    hit_vctl = (paddr == lcdpb_pkg::OFF_VCTL);
    hit_sel[0] = (paddr == lcdpb_pkg::OFF_SEL0);
    hit_sel[1] = (paddr == lcdpb_pkg::OFF_SEL1);
    hit_sel[2] = (paddr == lcdpb_pkg::OFF_SEL2);
    hit_sel[3] = (paddr == lcdpb_pkg::OFF_SEL3);
    mapped = hit_vctl || (hit_sel != 4'h0);
    rdata_next = 32'h0;
    if (hit_vctl) begin
      rdata_next = {16'h0, vctl_reg};
    end
    for (int i = 0; i < lcdpb_pkg::NUM_SEL; i++) begin
      if (hit_sel[i]) begin
        rdata_next = {16'h0, sel_reg[i]};
      end
    end
  end

  assign setup = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  // zero wait states: read data is prepared in the setup cycle
  assign pready = psel && penable;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0 : rdata_next;
      pslverr <= !mapped;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vctl_reg <= lcdpb_pkg::VCTL_RESET;
    end else if (access_wr && hit_vctl) begin
      vctl_reg <= pwdata[15:0] & lcdpb_pkg::VCTL_RW_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < lcdpb_pkg::NUM_SEL; i++) begin
        sel_reg[i] <= lcdpb_pkg::SEL_RESET; // [R11]
      end
    end else if (access_wr) begin
      for (int i = 0; i < lcdpb_pkg::NUM_SEL; i++) begin
        if (hit_sel[i]) begin
          // reserved lines of the variant never store
          sel_reg[i] <= pwdata[15:0] & // [R7] [R14]
                        lcdpb_pkg::seg_mask(i, SEG_MAX, COM_SHARED); // [R8] [R9] [R10]
        end
      end
    end
  end

  assign sel_flat = {sel_reg[3], sel_reg[2], sel_reg[1], sel_reg[0]};

  lcdpb_bias u_bias (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .vctl(lcdpb_pkg::vctl_unpack(vctl_reg)),
    .mux_ratio(mux_ratio),
    .bias(bias)
  );

  lcdpb_pinsel #(
    .DEDICATED(DEDICATED)
  ) u_pinsel (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sel_flat(sel_flat),
    .seg_lcd_func(seg_lcd_func)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  pump_gating_a: assert property ( // [R1]
    ##1 bias.pump_on == ($past(vctl_reg[lcdpb_pkg::POS_PUMP_EN]) &&
      !$past(vctl_reg[lcdpb_pkg::POS_VLCD_EXT]) && ($past(vctl_reg[12:9]) != 4'h0 ||
      $past(vctl_reg[2:1]) != 2'h0)))
    else $error("pump enable does not follow its gating terms");

  ref_reserved_a: assert property ( // [R2]
    (vctl_reg[2:1] == lcdpb_pkg::REF_RSVD && vctl_reg[7] == 1'b0 && vctl_reg[5] == 1'b0)
    |=> bias.ref_ext && !bias.ref_int)
    else $error("reserved reference code not taken as external");

  ref_fallback_a: assert property ( // [R3]
    (vctl_reg[7] || vctl_reg[5]) |=> bias.ref_int && !bias.ref_ext && !bias.ref_to_pin)
    else $error("reference did not fall back to internal");

  half_bias_a: assert property ( // [R4]
    (mux_ratio <= lcdpb_pkg::MUX_STATIC || mux_ratio > lcdpb_pkg::MUX_MAX_HALF)
    |=> !bias.half_bias)
    else $error("half bias chosen in a mode that ignores it");

  pin_func_a: assert property ( // [R5]
    ##1 seg_lcd_func == ($past(sel_flat[53:0]) | DEDICATED))
    else $error("pin function does not follow enable register");

  sel3_reserved_a: assert property ( // [R7]
    sel_reg[3][15:6] == 10'h0)
    else $error("reserved bits of fourth enable register set");

  masked_store_a: assert property ( // [R14]
    (access_wr && hit_sel[2]) |=>
      sel_reg[2] == ($past(pwdata[15:0]) & lcdpb_pkg::seg_mask(2, SEG_MAX, COM_SHARED)))
    else $error("enable register stored bits outside its mask");

  readback_a: assert property ( // [R11]
    (setup && !pwrite && hit_sel[1]) |=> prdata == {16'h0, $past(sel_reg[1])} && !pslverr)
    else $error("enable register readback wrong");

  bias_gen_a: assert property ( // [R12]
    vctl_reg[5] |=> !bias.int_bias_on && !bias.bias_to_pins)
    else $error("internal bias generator left on with external bias");

  bias_pins_a: assert property ( // [R13]
    (!vctl_reg[5] && vctl_reg[7]) |=> bias.bias_to_pins && bias.int_bias_on)
    else $error("internal bias levels not routed to pins");

  unmapped_err_a: assert property (
    (setup && !mapped) |=> pslverr && prdata == 32'h0)
    else $error("unmapped address answered without error");

  variant_mask_a: assert property ( // [R8] [R9] [R10]
    (sel_reg[1] & ~lcdpb_pkg::seg_mask(1, SEG_MAX, COM_SHARED)) == 16'h0 &&
    (sel_reg[2] & ~lcdpb_pkg::seg_mask(2, SEG_MAX, COM_SHARED)) == 16'h0)
    else $error("reserved segment line of this variant stored");
endmodule

/* logic/lcdpb_pkg.sv */
// constants, types and helpers for the display pin and bias configuration block
// Functional notes
// [R1] pump runs only if enabled, supply internal, and voltage or reference field nonzero
// [R2] reference field: 00 internal, 01 external, 10 internal to pin, 11 external
// [R3] external bias or bias-to-pins forces the internal reference
// [R4] bias bit picks 1/3 or 1/2 bias; ignored in static and five-mux or more
// [R5] enable bit 0 gives pin to port, 1 to display; dedicated pins stay display
// [R6] software should change these settings only while the display is off
// [R7] fourth enable register holds lines 48 to 53 in bits 5:0, rest read zero; the code stores them only for 384 segments with shared commons
// [R8] 192 segments: line 31 reserved if commons shared, else lines 24 to 31
// [R9] 256 segments: lines 39 to 47 reserved if commons shared, else third register absent
// [R10] 320 segments: line 47 reserved if commons shared, else lines 40 to 47
// [R11] three full enable registers map lines 0-15, 16-31, 32-47, bit is line mod 16
// [R12] external bias takes intermediate levels from outside and stops the bias generator
// [R13] internal bias with bias-to-pins set drives intermediate levels onto their pins
// [R14] reserved or absent enable bits read zero and ignore writes
package lcdpb_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_VCTL = 12'h000;
  localparam logic [11:0] OFF_SEL0 = 12'h004;
  localparam logic [11:0] OFF_SEL1 = 12'h008;
  localparam logic [11:0] OFF_SEL2 = 12'h00c;
  localparam logic [11:0] OFF_SEL3 = 12'h010;
  localparam int NUM_SEL = 4;
  localparam int SEG_LINES = 54;

  localparam int POS_BIAS_HALF = 0;
  localparam int POS_REF_LSB = 1;
  localparam int POS_PUMP_EN = 3;
  localparam int POS_VLCD_EXT = 4;
  localparam int POS_EXT_BIAS = 5;
  localparam int POS_V5_PIN = 6;
  localparam int POS_BIAS_PINS = 7;
  localparam int POS_VSEL_LSB = 9;

  localparam logic [15:0] VCTL_RW_MASK = 16'h1eff;
  localparam logic [15:0] VCTL_RESET = 16'h0000;
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [15:0] SEL3_MASK = 16'h003f;

  localparam logic [1:0] REF_INT = 2'h0;
  localparam logic [1:0] REF_EXT = 2'h1;
  localparam logic [1:0] REF_INT_PIN = 2'h2;
  localparam logic [1:0] REF_RSVD = 2'h3;

  localparam logic [3:0] MUX_STATIC = 4'h1;
  localparam logic [3:0] MUX_MAX_HALF = 4'h4;

  typedef struct packed {
    logic [3:0] vsel;
    logic bias_pins;
    logic v5_pin_sel;
    logic ext_bias;
    logic vlcd_ext;
    logic pump_en;
    logic [1:0] ref_sel;
    logic bias_half;
  } lcdpb_vctl_s;

  typedef struct packed {
    logic pump_on;
    logic ref_int;
    logic ref_ext;
    logic ref_to_pin;
    logic half_bias;
    logic int_bias_on;
    logic bias_to_pins;
    logic v5_from_pin;
  } lcdpb_bias_s;

  function automatic lcdpb_vctl_s vctl_unpack(input logic [15:0] r);
    lcdpb_vctl_s v;
    v.vsel = r[POS_VSEL_LSB+:4];
    v.bias_pins = r[POS_BIAS_PINS];
    v.v5_pin_sel = r[POS_V5_PIN];
    v.ext_bias = r[POS_EXT_BIAS];
    v.vlcd_ext = r[POS_VLCD_EXT];
    v.pump_en = r[POS_PUMP_EN];
    v.ref_sel = r[POS_REF_LSB+:2];
    v.bias_half = r[POS_BIAS_HALF];
    return v;
  endfunction

  // writable bits of enable register idx for a device variant
  function automatic logic [15:0] seg_mask(input int idx, input int seg_max,
                                           input logic com_shared);
    logic [15:0] m;
    m = 16'hffff;
    if (idx == 3) begin
      m = (seg_max == 384 && com_shared) ? SEL3_MASK : 16'h0000;
    end else if (seg_max == 192) begin
      if (idx == 1) begin
        m = com_shared ? 16'h7fff : 16'h00ff;
      end else if (idx == 2) begin
        m = 16'h0000;
      end
    end else if (seg_max == 256 && idx == 2) begin
      m = com_shared ? 16'h007f : 16'h0000;
    end else if (seg_max == 320 && idx == 2) begin
      m = com_shared ? 16'h7fff : 16'h00ff;
    end
    return m;
  endfunction
endpackage

/* logic/lcdpb_bias.sv */
// pump gating, reference selection and bias decoding
`timescale 1ns/1ps
module lcdpb_bias (
  input wire logic ref_clk,
  input wire logic resetn,
  input lcdpb_pkg::lcdpb_vctl_s vctl,
  input wire logic [3:0] mux_ratio,
  output lcdpb_pkg::lcdpb_bias_s bias
);
  logic [1:0] ref_eff;
  lcdpb_pkg::lcdpb_bias_s bias_next;

  always_comb begin
    // external bias or bias-to-pins makes the reference fall back to internal
    ref_eff = (vctl.ext_bias || vctl.bias_pins) ? lcdpb_pkg::REF_INT : vctl.ref_sel; // [R3]
    bias_next.pump_on = vctl.pump_en && !vctl.vlcd_ext &&
                        (vctl.vsel != 4'h0 || vctl.ref_sel != lcdpb_pkg::REF_INT); // [R1]
    bias_next.ref_int = (ref_eff == lcdpb_pkg::REF_INT) ||
                        (ref_eff == lcdpb_pkg::REF_INT_PIN); // [R2]
    bias_next.ref_ext = (ref_eff == lcdpb_pkg::REF_EXT) ||
                        (ref_eff == lcdpb_pkg::REF_RSVD); // [R2]
    bias_next.ref_to_pin = (ref_eff == lcdpb_pkg::REF_INT_PIN); // [R2]
    bias_next.half_bias = vctl.bias_half && (mux_ratio > lcdpb_pkg::MUX_STATIC) &&
                          (mux_ratio <= lcdpb_pkg::MUX_MAX_HALF); // [R4]
    bias_next.int_bias_on = !vctl.ext_bias; // [R12]
    bias_next.bias_to_pins = !vctl.ext_bias && vctl.bias_pins; // [R13]
    bias_next.v5_from_pin = vctl.v5_pin_sel;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bias <= '0;
    end else begin
      bias <= bias_next;
    end
  end
endmodule

/* logic/lcdpb_pinsel.sv */
// hands each segment pin to the port or the display function
`timescale 1ns/1ps
module lcdpb_pinsel #(
  parameter logic [53:0] DEDICATED = 54'h0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [63:0] sel_flat,
  output logic [53:0] seg_lcd_func
);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      seg_lcd_func <= DEDICATED;
    end else begin
      seg_lcd_func <= sel_flat[53:0] | DEDICATED; // [R5] [R11]
    end
  end
endmodule

/* dv/lcd_pin_and_bias_config_bench.sv */
// self-checking bench for the display pin and bias configuration block
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module lcd_pin_and_bias_config_bench;
  localparam logic [53:0] DED = 54'h3;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] mux_ratio = 4'h1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  lcdpb_pkg::lcdpb_bias_s bias;
  logic [53:0] seg_lcd_func;
  logic [53:0] seg_lcd_func_192;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  lcdpb_top #(.SEG_MAX(384), .COM_SHARED(1'b1), .DEDICATED(DED)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mux_ratio(mux_ratio), .bias(bias),
    .seg_lcd_func(seg_lcd_func));
  lcdpb_top #(.SEG_MAX(192), .COM_SHARED(1'b0), .DEDICATED(DED)) dut_192 (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .mux_ratio(mux_ratio), .bias(), .seg_lcd_func(seg_lcd_func_192));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {16'h0, d}, r, e);
  endtask
  function automatic logic [7:0] exp_bias(input logic [15:0] v, input logic [3:0] m);
    logic [1:0] ef;
    ef = (v[5] | v[7]) ? 2'h0 : v[2:1];
    return {v[3] & !v[4] & (v[12:9] != 4'h0 || v[2:1] != 2'h0),
            ef == 2'h0 || ef == 2'h2, ef[0], ef == 2'h2,
            v[0] & (m >= 4'h2) & (m <= 4'h4), !v[5], v[7] & !v[5], v[6]};
  endfunction
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0, r, e);
      `CHK("reset read", 32'h0, r)
      `CHK("reset err", 1'b0, e)
    end
    `CHK("reset seg", DED, seg_lcd_func)
    `CHK("reset bias", 8'h44, 8'(bias))
    apb(1'b0, 12'h014, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
  endtask
  task automatic t_vctl();
    logic [31:0] r;
    logic e;
    logic [15:0] v;
    wr(12'h000, 16'hffff);
    apb(1'b0, 12'h000, 32'h0, r, e);
    `CHK("vctl mask", 32'h00001eff, r)
    for (int i = 0; i < 1024; i++) begin
      v = {3'h0, i[8] ? 4'h5 : 4'h0, 1'b0, i[7:0]};
      mux_ratio <= 4'(i % 9);
      wr(12'h000, v);
      repeat (3) @(posedge ref_clk);
      `CHK("bias", exp_bias(v, 4'(i % 9)), 8'(bias))
    end
  endtask
  task automatic t_seg();
    logic [31:0] r;
    logic e;
    logic [15:0] pat [4] = '{16'h1234, 16'h5678, 16'h9abc, 16'hffff};
    logic [15:0] rb [4] = '{16'h1234, 16'h5678, 16'h9abc, 16'h003f};
    for (int i = 0; i < 4; i++) begin
      wr(12'(4 + i * 4), pat[i]);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 + i * 4), 32'h0, r, e);
      `CHK("seg read", {16'h0, rb[i]}, r)
    end
    repeat (2) @(posedge ref_clk);
    `CHK("seg func", {6'h3f, 16'h9abc, 16'h5678, 16'h1234} | DED, seg_lcd_func)
    `CHK("seg 192", {6'h0, 16'h0, 16'h0078, 16'h1234} | DED, seg_lcd_func_192)
    for (int i = 0; i < 4; i++) begin
      wr(12'(4 + i * 4), 16'h0);
    end
    repeat (3) @(posedge ref_clk);
    `CHK("seg port", DED, seg_lcd_func)
    `CHK("seg port 192", DED, seg_lcd_func_192)
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_vctl();
    t_seg();
    conclude();
  end
endmodule
